// >>> src/modbus_port_cfg.sv
// Purpose: settings, addressing and reply path of the serial slave port
// Assumes: requests arrive already deframed, one per handshake
// Notes:   new settings wait in pending copies until a serial restart
`timescale 1ns/1ps
module modbus_port_cfg
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_station,
  input  wire logic        req_write,
  input  wire logic [15:0] req_register,
  input  wire logic [15:0] req_data,
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic [15:0]      rsp_data,
  output logic             rsp_error,
  output logic [3:0]       rsp_format,
  output logic [3:0]       rsp_rate,
  output logic [3:0]       cfg_format,
  output logic [3:0]       cfg_rate,
  output logic [7:0]       cfg_station
);
  logic [3:0]  format_reg;
  logic [3:0]  rate_reg;
  logic [7:0]  station_reg;
  logic [3:0]  format_active_reg;
  logic [3:0]  rate_active_reg;
  logic [7:0]  station_active_reg;
  logic        take;
  logic        own;
  logic        bcast;
  logic        exec_write;
  logic [16:0] dec;
  logic        dec_ok;
  logic        hit_format;
  logic        hit_rate;
  logic        hit_station;
  logic        hit_restart;
  logic        bad_value;
  logic        restart_fire;
  logic [15:0] rd_data;
  logic        rsp_err;

  reply_buf_if rb ();

  // register number to {ok, menu, param}
  function automatic logic [16:0] decode_register(input logic [15:0] reg_num, input logic modified);
    logic [16:0] addr;
    logic [16:0] menu;
    logic [16:0] param;
    logic        ok;
    addr = {1'b0, reg_num} + 17'h00001;
    if (modified)
    begin
      menu  = addr >> 8;
      param = {9'h000, addr[7:0]};
      ok    = (menu <= modbus_cfg_pkg::MOD_MENU_MAX);
    end
    else
    begin
      menu  = addr / modbus_cfg_pkg::STD_SCALE;
      param = addr % modbus_cfg_pkg::STD_SCALE;
      ok    = (menu <= modbus_cfg_pkg::STD_MENU_MAX);
    end
    if ((menu > modbus_cfg_pkg::MOD_MENU_MAX) && (param > modbus_cfg_pkg::PARAM_LIMIT))
      ok = 1'b0;
    return {ok, menu[7:0], param[7:0]};
  endfunction

  // request acceptance and station matching
  assign req_ready  = rb.in_ready;
  assign take       = req_valid && rb.in_ready;
  assign own        = (req_station == station_active_reg);
  assign bcast      = (req_station == modbus_cfg_pkg::BROADCAST);
  assign exec_write = take && req_write && (own || bcast);

  // numbering scheme follows the active mode bit
  assign dec         = decode_register(req_register, format_active_reg[modbus_cfg_pkg::FMT_MODE_BIT]);
  assign dec_ok      = dec[16];
  assign hit_format  = dec_ok && (dec[15:8] == modbus_cfg_pkg::SETTINGS_MENU)
                       && (dec[7:0] == modbus_cfg_pkg::FORMAT_PARAM);
  assign hit_rate    = dec_ok && (dec[15:8] == modbus_cfg_pkg::SETTINGS_MENU)
                       && (dec[7:0] == modbus_cfg_pkg::RATE_PARAM);
  assign hit_station = dec_ok && (dec[15:8] == modbus_cfg_pkg::SETTINGS_MENU)
                       && (dec[7:0] == modbus_cfg_pkg::STATION_PARAM);
  assign hit_restart = dec_ok && (dec[15:8] == modbus_cfg_pkg::SETTINGS_MENU)
                       && (dec[7:0] == modbus_cfg_pkg::RESTART_PARAM);
  assign restart_fire = exec_write && hit_restart && (req_data != 16'h0000);

  // value checks on writes
  always_comb
  begin
    bad_value = 1'b0;
    if (req_write && hit_rate && (req_data > {12'h000, modbus_cfg_pkg::RATE_MAX}))
      bad_value = 1'b1;
    if (req_write && hit_station && ((req_data == 16'h0000)
        || (req_data > {8'h00, modbus_cfg_pkg::STATION_MAX})))
      bad_value = 1'b1;
  end

  // pending settings, written by the master
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      format_reg  <= modbus_cfg_pkg::FORMAT_RESET;
      rate_reg    <= modbus_cfg_pkg::RATE_RESET;
      station_reg <= modbus_cfg_pkg::STATION_RESET;
    end
    else if (exec_write && !bad_value)
    begin
      if (hit_format)
        format_reg <= {1'b0, req_data[2:0]};
      if (hit_rate)
        rate_reg <= req_data[3:0];
      if (hit_station)
        station_reg <= req_data[7:0];
    end
  end

  // active settings change only on restart, all at once
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      format_active_reg  <= modbus_cfg_pkg::FORMAT_RESET;
      rate_active_reg    <= modbus_cfg_pkg::RATE_RESET;
      station_active_reg <= modbus_cfg_pkg::STATION_RESET;
    end
    else if (restart_fire)
    begin
      format_active_reg  <= format_reg;
      rate_active_reg    <= rate_reg;
      station_active_reg <= station_reg;
    end
  end

  // read data and error flag
  always_comb
  begin
    rd_data = 16'h0000;
    rsp_err = 1'b0;
    if (hit_format)
      rd_data = {12'h000, format_reg};
    else if (hit_rate)
      rd_data = {12'h000, rate_reg};
    else if (hit_station)
      rd_data = {8'h00, station_reg};
    else if (!hit_restart)
      rsp_err = 1'b1;
    if (bad_value)
      rsp_err = 1'b1;
  end

  // replies only to own-station requests, framed with the settings in force
  assign rb.in_valid  = take && own;
  assign rb.in_data   = {format_active_reg, rate_active_reg, rsp_err, rd_data};
  assign rb.out_ready = rsp_ready;

  reply_buf u_buf
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .bus     (rb)
  );

  // outputs
  assign rsp_valid   = rb.out_valid;
  assign rsp_format  = rb.out_data[24:21];
  assign rsp_rate    = rb.out_data[20:17];
  assign rsp_error   = rb.out_data[16];
  assign rsp_data    = rb.out_data[15:0];
  assign cfg_format  = format_active_reg;
  assign cfg_rate    = rate_active_reg;
  assign cfg_station = station_active_reg;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence fmt_write_s;
    exec_write && hit_format && !restart_fire;
  endsequence
  sequence restart_s;
    restart_fire;
  endsequence

  a_reset_values: assert property ($past(!nrst) |-> cfg_format == 4'h0 && cfg_station == 8'h01)
    else $error("settings not at reset values");
  a_len_bit_zero: assert property (format_reg[modbus_cfg_pkg::FMT_LEN_BIT] == 1'b0)
    else $error("data length bit set");
  a_hold_pending: assert property (!restart_fire |=> $stable(cfg_format) && $stable(cfg_rate))
    else $error("active settings moved without restart");
  a_restart_latch: assert property (restart_fire |=> cfg_station == $past(station_reg)
                                     && cfg_rate == $past(rate_reg))
    else $error("restart did not latch settings");
  a_format_apply: assert property (fmt_write_s ##1 restart_s |=> cfg_format[2:0] == $past(req_data[2:0], 2))
    else $error("format not applied after restart");
  // a reply pushed into an empty buffer shows the framing that was in force when it was taken
  a_reply_framing: assert property (rb.in_valid && !rb.out_valid |=> rsp_valid && rsp_format == $past(cfg_format))
    else $error("reply framed with new settings");
  a_slave_only: assert property (rb.in_valid |-> take && req_station == cfg_station)
    else $error("reply without own request");
  a_bcast_quiet: assert property (take && bcast |-> !rb.in_valid)
    else $error("broadcast answered");
  a_station_range: assert property (station_reg != 8'h00 && station_reg <= 8'hf7)
    else $error("station address out of range");
  a_std_decode: assert property (req_register == 16'h0463 && !cfg_format[2] |-> hit_format)
    else $error("standard numbering wrong");
  a_mod_decode: assert property (req_register == 16'h0b17 && cfg_format[2] |-> hit_format)
    else $error("modified numbering wrong");
  a_high_menu: assert property (cfg_format[2] && req_register >= 16'h3fff |-> !dec_ok)
    else $error("unreachable register decoded");
  // the reply to a restart still carries the line rate that was active before it
  a_rate_reply: assert property (restart_fire && rb.in_valid && !rb.out_valid |=> rsp_valid && rsp_rate == $past(cfg_rate))
    else $error("restart reply sent at new rate");
endmodule

// >>> common/modbus_cfg_pkg.sv
// Purpose: constants for the serial slave port configuration block
// Assumes: one clock, synchronous active-low reset
// Notes:   menu and parameter numbers held as 8-bit values
package modbus_cfg_pkg;
  // frame format setting layout and reset value
  localparam int          FMT_LEN_BIT    = 3;
  localparam int          FMT_MODE_BIT   = 2;
  localparam logic [3:0]  FORMAT_RESET   = 4'h0;
  // line rate code and station address
  localparam logic [3:0]  RATE_RESET     = 4'h6;
  localparam logic [3:0]  RATE_MAX       = 4'ha;
  localparam logic [7:0]  STATION_RESET  = 8'h01;
  localparam logic [7:0]  STATION_MAX    = 8'hf7;
  localparam logic [7:0]  BROADCAST      = 8'h00;
  // menu and parameter numbers of the port settings
  localparam logic [7:0]  SETTINGS_MENU  = 8'h0b;
  localparam logic [7:0]  RESTART_PARAM  = 8'h14;
  localparam logic [7:0]  STATION_PARAM  = 8'h17;
  localparam logic [7:0]  FORMAT_PARAM   = 8'h18;
  localparam logic [7:0]  RATE_PARAM     = 8'h19;
  // register number conversion limits
  localparam logic [16:0] STD_SCALE      = 17'h00064;
  localparam logic [16:0] STD_MENU_MAX   = 17'h000a2;
  localparam logic [16:0] MOD_MENU_MAX   = 17'h0003f;
  localparam logic [16:0] PARAM_LIMIT    = 17'h00063;
  // reply word: {format, rate, error, data}
  localparam int          RSP_W          = 25;

  // character framing held in the two low bits
  typedef enum logic [1:0] {
    two_stop_option    = 2'h0,
    no_parity_option   = 2'h1,
    even_parity_option = 2'h2,
    odd_parity_option  = 2'h3
  } framing_type;
endpackage

// >>> common/reply_buf_if.sv
// Purpose: carrier between the request logic and the reply buffer
// Assumes: valid/ready handshake on both sides
// Notes:   a word moves when valid and ready are both high
`timescale 1ns/1ps
interface reply_buf_if;
  logic                            in_valid;
  logic                            in_ready;
  logic [modbus_cfg_pkg::RSP_W-1:0] in_data;
  logic                            out_valid;
  logic                            out_ready;
  logic [modbus_cfg_pkg::RSP_W-1:0] out_data;
  modport fill  (output in_valid, input in_ready, output in_data,
                 input out_valid, output out_ready, input out_data);
  modport store (input in_valid, output in_ready, input in_data,
                 output out_valid, input out_ready, output out_data);
endinterface

// >>> src/reply_buf.sv
// Purpose: two-entry reply buffer
// Assumes: synchronous active-low reset
// Notes:   full and empty are exact; a full buffer drops ready
`timescale 1ns/1ps
module reply_buf
(
  input wire logic   ref_clk,
  input wire logic   nrst,
  reply_buf_if.store bus
);
  logic [modbus_cfg_pkg::RSP_W-1:0] mem_reg [2];
  logic                             wr_ptr_reg;
  logic                             rd_ptr_reg;
  logic [1:0]                       count_reg;
  logic                             push;
  logic                             pop;

  // handshake and occupancy
  assign bus.in_ready  = (count_reg != 2'h2);
  assign bus.out_valid = (count_reg != 2'h0);
  assign bus.out_data  = mem_reg[rd_ptr_reg];
  assign push          = bus.in_valid && bus.in_ready;
  assign pop           = bus.out_valid && bus.out_ready;

  // storage
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= bus.in_data;
  end

  // pointers and count
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        count_reg <= count_reg + 2'h1;
      else if (pop && !push)
        count_reg <= count_reg - 2'h1;
    end
  end
endmodule

// >>> sim/modbus_master_model.sv
// Purpose: bus master stand-in that issues requests to the slave port
// Assumes: request lines change 1 ns after a rising edge
// Notes:   idle request lines carry the inverse of their last value
`timescale 1ns/1ps
module modbus_master_model
(
  input  wire logic  ref_clk,
  input  wire logic  hold,
  input  wire logic  req_ready,
  output logic       req_valid,
  output logic [7:0] req_station,
  output logic       req_write,
  output logic [15:0] req_register,
  output logic [15:0] req_data,
  output logic       rsp_ready
);
  logic stall_now;

  // start quiet
  initial
  begin
    req_valid = 1'b0;
    req_station = 8'h00;
    req_write = 1'b0;
    req_register = 16'h0000;
    req_data = 16'h0000;
    rsp_ready = 1'b0;
  end

  // accept replies at random, or not at all while held
  always
  begin
    @(posedge ref_clk);
    stall_now = hold;
    #1;
    rsp_ready = !stall_now && ($urandom_range(3) != 0);
  end

  // present one request and hold it until the port takes it
  task automatic send(input logic [7:0] st, input logic wr, input logic [15:0] rg, input logic [15:0] dt);
    req_valid = 1'b1;
    req_station = st;
    req_write = wr;
    req_register = rg;
    req_data = dt;
    do @(negedge ref_clk); while (req_ready !== 1'b1);
    @(posedge ref_clk);
    #1;
  endtask

  // release the request; stale lines must not look valid
  task automatic idle();
    req_valid = 1'b0;
    req_station = ~req_station;
    req_write = ~req_write;
    req_register = ~req_register;
    req_data = ~req_data;
    @(posedge ref_clk);
    #1;
  endtask

  // quiet gap after a settings change before talking in the new format;
  // the port here has no character timing, so a short gap stands in for the long line pause
  task automatic settle(input int cycles);
    idle();
    repeat (cycles) @(posedge ref_clk);
    #1;
  endtask
endmodule

// >>> sim/tb.sv
// Purpose: self-checking bench for the serial slave port settings
// Assumes: master model drives requests, bench predicts every reply
// Notes:   replies are noted at request time and popped on delivery
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hold = 1'b0;
  logic        req_valid, req_ready, req_write, rsp_valid, rsp_ready, rsp_error;
  logic [7:0]  req_station, cfg_station, act_st, ps;
  logic [15:0] req_register, req_data, rsp_data;
  logic [3:0]  rsp_format, rsp_rate, cfg_format, cfg_rate, act_fmt, act_rate, pf, pr;
  logic [24:0] exp_q[$], msk_q[$], m_cur;
  int          fail_count = 0;
  int          compares = 0;

  always #20 ref_clk = ~ref_clk;

  modbus_port_cfg u_modbus_port_cfg (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_station(req_station), .req_write(req_write), .req_register(req_register),
    .req_data(req_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .rsp_format(rsp_format), .rsp_rate(rsp_rate), .cfg_format(cfg_format),
    .cfg_rate(cfg_rate), .cfg_station(cfg_station));

  modbus_master_model u_master (.ref_clk(ref_clk), .hold(hold), .req_ready(req_ready),
    .req_valid(req_valid), .req_station(req_station), .req_write(req_write),
    .req_register(req_register), .req_data(req_data), .rsp_ready(rsp_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // active settings against the predicted ones
  task automatic cfg_chk();
    check({16'h0000, cfg_format, cfg_rate, cfg_station}, {16'h0000, act_fmt, act_rate, act_st});
  endtask

  // predict the reply and pending settings, then issue the request
  task automatic req(input logic [7:0] st, input logic wr, input logic [15:0] rg, input logic [15:0] dt);
    logic [16:0] n;
    logic [16:0] q;
    logic [16:0] p;
    logic        err;
    logic        rst;
    logic [15:0] rd;
    n = {1'b0, rg} + 17'h00001;
    q = act_fmt[2] ? (n >> 8) : (n / 17'h00064);
    p = act_fmt[2] ? (n & 17'h000ff) : (n % 17'h00064);
    err = (q != 17'h0000b);
    rst = 1'b0;
    rd = 16'h0000;
    if ((st == act_st || st == 8'h00) && !err)
    begin
      case (p[7:0])
        8'h14: rst = wr && (dt != 16'h0000);
        8'h17: if (!wr) rd = {8'h00, ps}; else if (dt == 16'h0000 || dt > 16'h00f7) err = 1'b1; else ps = dt[7:0];
        8'h18: if (!wr) rd = {12'h000, pf}; else pf = {1'b0, dt[2:0]};
        8'h19: if (!wr) rd = {12'h000, pr}; else if (dt > 16'h000a) err = 1'b1; else pr = dt[3:0];
        default: err = 1'b1;
      endcase
    end
    if (st == act_st)
    begin
      exp_q.push_back({act_fmt, act_rate, err, rd});
      msk_q.push_back(wr ? 25'h1ff0000 : 25'h1ffffff);
    end
    if (rst)
    begin
      act_fmt = pf;
      act_rate = pr;
      act_st = ps;
    end
    u_master.send(st, wr, rg, dt);
  endtask

  // take the oldest note whenever a reply is delivered
  always @(posedge ref_clk)
  begin
    if (nrst === 1'b1 && rsp_valid === 1'b1 && rsp_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h00000001, 32'h00000000);
      else
      begin
        m_cur = msk_q.pop_front();
        check({7'h00, {rsp_format, rsp_rate, rsp_error, rsp_data} & m_cur}, {7'h00, exp_q.pop_front() & m_cur});
      end
    end
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hcde6));
    act_fmt = 4'h0;
    pf = 4'h0;
    act_rate = modbus_cfg_pkg::RATE_RESET;
    pr = modbus_cfg_pkg::RATE_RESET;
    act_st = 8'h01;
    ps = 8'h01;
    repeat (2) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    cfg_chk();
    req(8'($urandom_range(246, 2)), 1'b1, 16'h0463, 16'h0003);
    req(8'h01, 1'b1, 16'h0463, 16'h000f);
    req(8'h01, 1'b0, 16'h0463, 16'h0000);
    req(8'h01, 1'b1, 16'h0464, 16'($urandom_range(10)));
    req(8'h01, 1'b1, 16'h0464, 16'h000b);
    req(8'h01, 1'b1, 16'h0462, 16'h0000);
    req(8'h01, 1'b1, 16'h0462, 16'h00f8);
    req(8'h01, 1'b1, 16'h0462, 16'h00f7);
    req(8'h01, 1'b1, 16'h3fc3, 16'h0001);
    req(8'h01, 1'b0, 16'h0464, 16'h0000);
    cfg_chk();
    req(8'h01, 1'b1, 16'h045f, 16'h0001);
    cfg_chk();
    u_master.settle(8);
    // the port now answers to station f7 in modified numbering
    req(8'h01, 1'b0, 16'h0463, 16'h0000);
    req(8'h00, 1'b1, 16'h0b17, 16'h0004);
    req(8'h00, 1'b1, 16'h0b13, 16'h0001);
    cfg_chk();
    u_master.settle(8);
    for (int i = 0; i < 4; i++)
    begin
      req(8'hf7, 1'b1, 16'h0b17, {14'h0001, 2'(i)});
      req(8'hf7, 1'b1, 16'h0b13, 16'h0001);
      cfg_chk();
      u_master.settle(8);
    end
    req(8'hf7, 1'b0, 16'h4063, 16'h0000);
    req(8'hf7, 1'b0, 16'h0463, 16'h0000);
    u_master.idle();
    // drain every pending reply so that the stall starts from an empty buffer
    while (exp_q.size() != 0)
    begin
      @(posedge ref_clk);
      #1;
    end
    // stall the receiver until the buffer refuses
    hold = 1'b1;
    req(8'hf7, 1'b0, 16'h0b18, 16'h0000);
    req(8'hf7, 1'b0, 16'h0b16, 16'h0000);
    check({31'h0, req_ready}, 32'h00000000);
    fork
      req(8'hf7, 1'b0, 16'h0b17, 16'h0000);
      begin
        repeat (6) @(posedge ref_clk);
        #1;
        hold = 1'b0;
      end
    join
    u_master.idle();
    repeat (30) @(posedge ref_clk);
    check(32'(exp_q.size()), 32'h00000000);
    end_of_test();
  end

  // cut a hang short
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end
endmodule
